// ===== rtl/tkc_pkg.sv
// constants, register layouts and carriers of the timekeeper control block
package tkc_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int          TKC_ADDR_W         = 12;
    localparam logic [11:0] TKC_CTRL_OFFSET    = 12'h010;
    localparam logic [11:0] TKC_STATUS_OFFSET  = 12'h014;
    localparam logic [11:0] TKC_LOCK_OFFSET    = 12'h018;
    localparam logic [11:0] TKC_AUX_OFFSET     = 12'h01C;
    localparam logic [11:0] TKC_EVENT_OFFSET   = 12'h020;
    localparam logic [11:0] TKC_MASK_OFFSET    = 12'h024;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int TKC_STAT_INVALID_BIT   = 0;
    localparam int TKC_STAT_OVERFLOW_BIT  = 1;
    localparam int TKC_STAT_COUNT_EN_BIT  = 4;
    localparam int TKC_LOCK_FIELD_LSB     = 3;
    localparam int TKC_LOCK_ONE_BIT       = 7;
    localparam int TKC_AUX_WAKE_FORCE_BIT = 0;
    localparam int TKC_EV_OVERFLOW        = 0;
    localparam int TKC_EV_INVALID         = 1;
    localparam int TKC_EV_IGNORED         = 2;
    localparam int TKC_EV_BUS_ERROR       = 3;
    localparam int TKC_NUM_EVENTS         = 4;
    // lock field index: 3 lock-lock, 2 status, 1 control, 0 compensation
    localparam int TKC_LK_LOCK            = 3;
    localparam int TKC_LK_STATUS          = 2;
    localparam int TKC_LK_CONTROL         = 1;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [31:0] TKC_CTRL_RESET    = 32'h0000_0000;
    localparam logic [3:0]  TKC_LOCK_RESET    = 4'hF;
    localparam logic [3:0]  TKC_EVENT_RESET   = 4'h0;
    localparam logic [3:0]  TKC_MASK_RESET    = 4'h0;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [16:0] unused_hi;
        logic        reserved_14;
        logic [3:0]  load_trim;            // [3] 2pF .. [0] 16pF
        logic        clock_out_gate;
        logic        oscillator_enable;
        logic [2:0]  reserved_7_5;
        logic        wake_pin_source;
        logic        update_mode;
        logic        privileged_write_only;
        logic        wake_pin_enable;
        logic        soft_reset_bit;
    } tkc_ctrl_type;

    typedef struct packed {
        logic [11:0] paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
        logic [2:0]  pprot;
    } tkc_apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } tkc_apb_rsp_type;

    typedef struct packed {
        logic out;
        logic oe;
    } tkc_wake_type;

    typedef struct packed {
        tkc_ctrl_type    ctrl;
        logic            count_enable;
        logic            invalid;
        logic            overflow;
        logic [3:0]      lock;
        logic            wake_force;
        logic [3:0]      ev_status;
        logic [3:0]      ev_mask;
        tkc_apb_rsp_type rsp;
        logic            clk_sample;
        logic            periph_clk;
        logic            irq;
    } tkc_state_type;

endpackage

// ===== rtl/tkc_wake_pin.sv
// open-drain wakeup pin driver with clock-out option
module tkc_wake_pin (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  resetn,
    // control
    input  wire logic                  enable,
    input  wire logic                  source,
    input  wire logic                  gate,
    input  wire logic                  irq,
    input  wire logic                  force_on,
    input  wire logic                  clk32,
    // pin
    output tkc_pkg::tkc_wake_type      pin
);
    import tkc_pkg::*;

    tkc_wake_type pin_reg;
    tkc_wake_type pin_next;

    // ------------------------------------------------------------
    // pin selection
    // ------------------------------------------------------------
    always_comb begin
        pin_next.out = 1'b0;
        pin_next.oe  = 1'b0;
        if (enable) begin
            if (!source) begin
                pin_next.oe = irq | force_on;
            end else if (!gate) begin
                pin_next.oe  = 1'b1;
                pin_next.out = clk32;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pin_reg <= '0;
        end else begin
            pin_reg <= pin_next;
        end
    end

    assign pin = pin_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_wake_disabled: assert property (@(posedge clk) disable iff (!resetn)
        !enable |=> !pin.oe) else $error("wake pin driven while disabled");
    chk_wake_open_drain: assert property (@(posedge clk) disable iff (!resetn)
        enable && !source && (irq || force_on) |=> pin.oe && !pin.out)
        else $error("wake pin not pulled low");
    chk_wake_clock_out: assert property (@(posedge clk) disable iff (!resetn)
        enable && source |=> pin.oe == !$past(gate))
        else $error("wake clock output wrong");
endmodule

// ===== rtl/tkc_control.sv
// timekeeper control, status and lock registers behind an APB slave
// Contract
// - load trim bits switch 2/4/8/16 pF
// - clock gate bit withholds 32 kHz clock
// - oscillator enable bit switches oscillator
// - bits 7..5 read as zero
// - open-drain low on interrupt or force
// - source one outputs routed 32 kHz clock
// - update mode allows count enable under lock
// - no update mode, locked writes ignored
// - non-supervisor write errors unless permitted
// - wake enable zero disables the pin
// - soft reset resets all but itself; the code also keeps the control lock, event status and event mask
// - soft reset bit cleared only by software/POR
// - control lock cleared ignores control writes
// - status lock cleared ignores status writes
// - invalid flag set by POR and soft reset
module tkc_control (
    // clock and reset
    input  wire logic                   SYS_CLK,
    input  wire logic                   RESETN,
    // register bus
    input  wire tkc_pkg::tkc_apb_req_type APB_REQ,
    output tkc_pkg::tkc_apb_rsp_type    APB_RSP,
    // oscillator
    input  wire logic                   OSC_CLK_IN,
    output logic [3:0]                  LOAD_TRIM,
    output logic                        OSC_ENABLE,
    output logic                        PERIPH_CLK32,
    // time counter link
    input  wire logic                   OVERFLOW_EVENT,
    input  wire logic                   TIME_SECONDS_WRITE,
    output logic                        TIME_COUNT_ENABLE,
    output logic                        TIME_INVALID,
    output logic                        TIME_OVERFLOW,
    output logic                        COMP_UNLOCKED,
    // wakeup pin and interrupt
    output logic                        WAKE_OUT,
    output logic                        WAKE_OE,
    output logic                        IRQ
);
    import tkc_pkg::*;

    tkc_state_type s_reg;
    tkc_state_type s_next;
    tkc_wake_type  wake_pin;

    logic          access;
    logic          commit;
    logic          wr_commit;
    logic          priv_fail;
    logic          hit_ctrl;
    logic          hit_status;
    logic          hit_lock;
    logic          hit_aux;
    logic          hit_event;
    logic          hit_mask;
    logic          mapped;
    logic          ce_writable;
    logic [3:0]    ev_set;
    logic [31:0]   rd_data;
    logic [31:0]   wd;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    assign hit_ctrl   = {APB_REQ.paddr[11:2], 2'b00} == TKC_CTRL_OFFSET;
    assign hit_status = {APB_REQ.paddr[11:2], 2'b00} == TKC_STATUS_OFFSET;
    assign hit_lock   = {APB_REQ.paddr[11:2], 2'b00} == TKC_LOCK_OFFSET;
    assign hit_aux    = {APB_REQ.paddr[11:2], 2'b00} == TKC_AUX_OFFSET;
    assign hit_event  = {APB_REQ.paddr[11:2], 2'b00} == TKC_EVENT_OFFSET;
    assign hit_mask   = {APB_REQ.paddr[11:2], 2'b00} == TKC_MASK_OFFSET;
    assign mapped     = hit_ctrl | hit_status | hit_lock | hit_aux | hit_event | hit_mask;
    assign wd         = APB_REQ.pwdata;

    // first access cycle, and the edge at which the transfer completes
    assign access    = APB_REQ.psel & APB_REQ.penable & ~s_reg.rsp.pready;
    assign commit    = APB_REQ.psel & APB_REQ.penable & s_reg.rsp.pready;
    assign wr_commit = commit & APB_REQ.pwrite & ~s_reg.rsp.pslverr;
    assign priv_fail = APB_REQ.pwrite & ~APB_REQ.pprot[0] & ~s_reg.ctrl.privileged_write_only;

    // count enable writable with the status lock open, or in update mode while invalid, overflow or count stopped
    assign ce_writable = s_reg.lock[TKC_LK_STATUS] |
                         (s_reg.ctrl.update_mode &
                          (s_reg.invalid | s_reg.overflow | ~s_reg.count_enable));

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always_comb begin
        rd_data = 32'h0000_0000;
        if (hit_ctrl) begin
            rd_data = s_reg.ctrl;
            rd_data[31:15] = 17'h0_0000;
            rd_data[14]    = 1'b0;
            rd_data[7:5]   = 3'h0;
        end else if (hit_status) begin
            rd_data[TKC_STAT_COUNT_EN_BIT] = s_reg.count_enable;
            rd_data[TKC_STAT_OVERFLOW_BIT] = s_reg.overflow;
            rd_data[TKC_STAT_INVALID_BIT]  = s_reg.invalid;
        end else if (hit_lock) begin
            rd_data[TKC_LOCK_ONE_BIT] = 1'b1;
            rd_data[TKC_LOCK_FIELD_LSB +: 4] = s_reg.lock;
        end else if (hit_aux) begin
            rd_data[TKC_AUX_WAKE_FORCE_BIT] = s_reg.wake_force;
        end else if (hit_event) begin
            rd_data[TKC_NUM_EVENTS-1:0] = s_reg.ev_status;
        end else if (hit_mask) begin
            rd_data[TKC_NUM_EVENTS-1:0] = s_reg.ev_mask;
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        ev_set = 4'h0;
        s_next.rsp.pready  = 1'b0;
        s_next.rsp.pslverr = 1'b0;
        s_next.clk_sample  = OSC_CLK_IN;
        // gated 32 kHz clock to other peripherals
        s_next.periph_clk  = s_reg.clk_sample & s_reg.ctrl.oscillator_enable &
                             ~s_reg.ctrl.clock_out_gate;

        // bus answer, one wait state
        if (access) begin
            s_next.rsp.pready  = 1'b1;
            s_next.rsp.pslverr = priv_fail | ~mapped;
            s_next.rsp.prdata  = APB_REQ.pwrite ? 32'h0000_0000 : rd_data;
            ev_set[TKC_EV_BUS_ERROR] = priv_fail | ~mapped;
        end

        // register writes
        if (wr_commit) begin
            if (hit_ctrl) begin
                if (s_reg.lock[TKC_LK_CONTROL]) begin
                    s_next.ctrl.load_trim             = wd[13:10];
                    s_next.ctrl.clock_out_gate        = wd[9];
                    s_next.ctrl.oscillator_enable     = wd[8];
                    s_next.ctrl.wake_pin_source       = wd[4];
                    s_next.ctrl.update_mode           = wd[3];
                    s_next.ctrl.privileged_write_only = wd[2];
                    s_next.ctrl.wake_pin_enable       = wd[1];
                    s_next.ctrl.soft_reset_bit        = wd[0];
                    // reserved bits are never stored
                    s_next.ctrl.reserved_14  = 1'b0;
                    s_next.ctrl.reserved_7_5 = 3'h0;
                    s_next.ctrl.unused_hi    = 17'h0_0000;
                end else begin
                    ev_set[TKC_EV_IGNORED] = 1'b1;
                end
            end
            if (hit_status) begin
                if (ce_writable) begin
                    s_next.count_enable = wd[TKC_STAT_COUNT_EN_BIT];
                end else begin
                    ev_set[TKC_EV_IGNORED] = 1'b1;
                end
            end
            if (hit_lock) begin
                if (s_reg.lock[TKC_LK_LOCK]) begin
                    // lock bits can only be cleared by software
                    s_next.lock = s_reg.lock & wd[TKC_LOCK_FIELD_LSB +: 4];
                end else begin
                    ev_set[TKC_EV_IGNORED] = 1'b1;
                end
            end
            if (hit_aux) begin
                s_next.wake_force = wd[TKC_AUX_WAKE_FORCE_BIT];
            end
            if (hit_event) begin
                s_next.ev_status = s_reg.ev_status & ~wd[TKC_NUM_EVENTS-1:0];
            end
            if (hit_mask) begin
                s_next.ev_mask = wd[TKC_NUM_EVENTS-1:0];
            end
        end

        // time counter flags
        if (TIME_SECONDS_WRITE && !s_reg.count_enable) begin
            s_next.invalid  = 1'b0;
            s_next.overflow = 1'b0;
        end
        if (OVERFLOW_EVENT && s_reg.count_enable) begin
            s_next.overflow = 1'b1;
            ev_set[TKC_EV_OVERFLOW] = 1'b1;
        end

        // soft reset holds control, status, wake force and lock in reset but itself and the control lock; events and mask keep
        if (s_reg.ctrl.soft_reset_bit) begin
            s_next.ctrl = TKC_CTRL_RESET;
            s_next.ctrl.soft_reset_bit = (wr_commit && hit_ctrl && s_reg.lock[TKC_LK_CONTROL]) ?
                                         wd[0] : 1'b1;
            s_next.count_enable = 1'b0;
            s_next.overflow     = 1'b0;
            s_next.invalid      = 1'b1;
            s_next.wake_force   = 1'b0;
            s_next.lock         = TKC_LOCK_RESET;
            s_next.lock[TKC_LK_CONTROL] = s_reg.lock[TKC_LK_CONTROL];
            ev_set[TKC_EV_INVALID] = ~s_reg.invalid;
        end

        // sticky events, set wins over clear
        s_next.ev_status = s_next.ev_status | ev_set;
        s_next.irq       = |(s_next.ev_status & s_next.ev_mask);
    end

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            s_reg              <= '0;
            s_reg.ctrl         <= TKC_CTRL_RESET;
            s_reg.invalid      <= 1'b1;
            s_reg.lock         <= TKC_LOCK_RESET;
            s_reg.ev_status    <= TKC_EVENT_RESET;
            s_reg.ev_mask      <= TKC_MASK_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------
    // wakeup pin
    // ------------------------------------------------------------
    tkc_wake_pin u_wake (
        .clk      (SYS_CLK),
        .resetn   (RESETN),
        .enable   (s_reg.ctrl.wake_pin_enable),
        .source   (s_reg.ctrl.wake_pin_source),
        .gate     (s_reg.ctrl.clock_out_gate),
        .irq      (s_reg.irq),
        .force_on (s_reg.wake_force),
        .clk32    (s_reg.periph_clk),
        .pin      (wake_pin)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign APB_RSP           = s_reg.rsp;
    assign LOAD_TRIM         = s_reg.ctrl.load_trim;
    assign OSC_ENABLE        = s_reg.ctrl.oscillator_enable;
    assign PERIPH_CLK32      = s_reg.periph_clk;
    assign TIME_COUNT_ENABLE = s_reg.count_enable;
    assign TIME_INVALID      = s_reg.invalid;
    assign TIME_OVERFLOW     = s_reg.overflow;
    assign COMP_UNLOCKED     = s_reg.lock[0];
    assign WAKE_OUT          = wake_pin.out;
    assign WAKE_OE           = wake_pin.oe;
    assign IRQ               = s_reg.irq;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN);

    chk_reserved_read_zero: assert property (
        access && !APB_REQ.pwrite && hit_ctrl |=> APB_RSP.prdata[7:5] == 3'h0 && APB_RSP.prdata[14] == 1'b0)
        else $error("reserved control bits read non-zero");
    chk_ctrl_lock_ignore: assert property (
        wr_commit && hit_ctrl && !s_reg.lock[TKC_LK_CONTROL] && !s_reg.ctrl.soft_reset_bit
        |=> $stable(s_reg.ctrl)) else $error("locked control register changed");
    chk_priv_write_err: assert property (
        access && APB_REQ.pwrite && !APB_REQ.pprot[0] && !s_reg.ctrl.privileged_write_only
        |=> APB_RSP.pready && APB_RSP.pslverr) else $error("user write not refused");
    chk_soft_reset_hold: assert property (
        s_reg.ctrl.soft_reset_bit |=> TIME_INVALID && !TIME_COUNT_ENABLE && !OSC_ENABLE)
        else $error("soft reset did not reset registers");
    chk_soft_bit_sticky: assert property (
        s_reg.ctrl.soft_reset_bit && !(wr_commit && hit_ctrl) |=> s_reg.ctrl.soft_reset_bit)
        else $error("soft reset bit cleared by itself");
    chk_clock_gate_off: assert property (
        s_reg.ctrl.clock_out_gate [*2] |-> !PERIPH_CLK32)
        else $error("gated clock reached peripherals");
    chk_ctrl_write_takes: assert property (
        wr_commit && hit_ctrl && s_reg.lock[TKC_LK_CONTROL] && !s_reg.ctrl.soft_reset_bit
        |=> OSC_ENABLE == $past(APB_REQ.pwdata[8]) && LOAD_TRIM == $past(APB_REQ.pwdata[13:10]))
        else $error("control write not applied");
    chk_status_lock_hold: assert property (
        wr_commit && hit_status && !s_reg.lock[TKC_LK_STATUS] && !s_reg.ctrl.update_mode
        && !s_reg.ctrl.soft_reset_bit |=> $stable(TIME_COUNT_ENABLE))
        else $error("locked status register changed");
    chk_update_mode_write: assert property (
        wr_commit && hit_status && s_reg.ctrl.update_mode && !s_reg.ctrl.soft_reset_bit
        && (s_reg.invalid || s_reg.overflow || !s_reg.count_enable)
        |=> TIME_COUNT_ENABLE == $past(APB_REQ.pwdata[TKC_STAT_COUNT_EN_BIT]))
        else $error("update mode write refused");
    chk_status_open_write: assert property (
        wr_commit && hit_status && s_reg.lock[TKC_LK_STATUS] && !s_reg.ctrl.soft_reset_bit
        |=> TIME_COUNT_ENABLE == $past(APB_REQ.pwdata[TKC_STAT_COUNT_EN_BIT]))
        else $error("open status write not applied");
    chk_reserved_not_stored: assert property (
        wr_commit && hit_ctrl
        |=> s_reg.ctrl.reserved_14 == 1'b0 && s_reg.ctrl.reserved_7_5 == 3'h0)
        else $error("reserved control bits stored");
endmodule

// ===== sim/test_tkc_control.sv
// self-checking bench of the timekeeper control block
module test_tkc_control;
    timeunit 1ns;
    timeprecision 1ns;
    import tkc_pkg::*;
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); end end

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic            sys_clk    = 1'b0;
    logic            resetn     = 1'b0;
    logic [2:0]      osc_cnt    = 3'h0;
    logic            ovf        = 1'b0;
    logic            sec_wr     = 1'b0;
    tkc_apb_req_type req        = '0;
    tkc_apb_rsp_type rsp;
    logic [3:0]      trim;
    logic            osc_en, pclk, time_count_enable, tinv, tovf, cunl, wout, woe, irq;
    logic [31:0]     rd;
    logic            er;
    int              errors     = 0;
    int              n_compared = 0;
    int              t;

    always #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) osc_cnt <= osc_cnt + 3'h1;

    tkc_control i_dut (
        .SYS_CLK(sys_clk), .RESETN(resetn), .APB_REQ(req), .APB_RSP(rsp),
        .OSC_CLK_IN(osc_cnt[2]), .LOAD_TRIM(trim), .OSC_ENABLE(osc_en), .PERIPH_CLK32(pclk),
        .OVERFLOW_EVENT(ovf), .TIME_SECONDS_WRITE(sec_wr), .TIME_COUNT_ENABLE(time_count_enable),
        .TIME_INVALID(tinv), .TIME_OVERFLOW(tovf), .COMP_UNLOCKED(cunl),
        .WAKE_OUT(wout), .WAKE_OE(woe), .IRQ(irq)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task end_sim;
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic p);
        int i;
        @(posedge sys_clk);
        req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d, pprot: {2'b00, p}};
        @(posedge sys_clk);
        req.penable <= 1'b1;
        i = 0;
        do begin
            @(posedge sys_clk);
            i++;
        end while (rsp.pready !== 1'b1 && i < 20);
        if (i >= 20) begin
            errors++;
            end_sim;
        end
        rd = rsp.prdata;
        er = rsp.pslverr;
        req <= '0;
        #1;
    endtask

    task w(input logic [11:0] a, input logic [31:0] d);
        apb(a, 1'b1, d, 1'b1);
    endtask

    task r(input logic [11:0] a);
        apb(a, 1'b0, 32'h0, 1'b1);
    endtask

    task cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task pulse(input bit s);
        @(posedge sys_clk);
        if (s) ovf <= 1'b1; else sec_wr <= 1'b1;
        @(posedge sys_clk);
        ovf <= 1'b0;
        sec_wr <= 1'b0;
        cyc(2);
    endtask

    task toggles;
        logic p;
        int   k;
        cyc(3);
        t = 0;
        p = pclk;
        for (k = 0; k < 32; k++) begin
            cyc(1);
            if (pclk !== p) t++;
            p = pclk;
        end
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_reset_priv;
        r(TKC_CTRL_OFFSET);
        `CHK("ctrl reset", 32'h0, rd)
        `CHK("invalid por", 1'b1, tinv)
        r(TKC_LOCK_OFFSET);
        `CHK("lock reset", 32'h0000_00F8, rd)
        `CHK("comp open", 1'b1, cunl)
        apb(TKC_CTRL_OFFSET, 1'b1, 32'h104, 1'b0);
        `CHK("user err", 1'b1, er)
        r(TKC_CTRL_OFFSET);
        `CHK("user ignored", 32'h0, rd)
        w(TKC_CTRL_OFFSET, 32'h0000_00E4);
        r(TKC_CTRL_OFFSET);
        `CHK("reserved zero", 32'h4, rd)
        apb(TKC_CTRL_OFFSET, 1'b1, 32'h104, 1'b0);
        `CHK("user ok", 1'b0, er)
        cyc(1);
        `CHK("osc on", 1'b1, osc_en)
    endtask

    task t_trim_gate;
        int i;
        for (i = 0; i < 4; i++) begin
            w(TKC_CTRL_OFFSET, 32'h104 | (32'h400 << i));
            cyc(1);
            `CHK("trim", 4'b0001 << i, trim)
        end
        w(TKC_CTRL_OFFSET, 32'h4);
        cyc(1);
        `CHK("osc off", 1'b0, osc_en)
        w(TKC_CTRL_OFFSET, 32'h104);
        toggles;
        `CHK("clk routed", 1'b1, t > 0)
        w(TKC_CTRL_OFFSET, 32'h304);
        toggles;
        `CHK("clk withheld", 0, t)
    endtask

    task t_wake_irq;
        w(TKC_AUX_OFFSET, 32'h1);
        w(TKC_CTRL_OFFSET, 32'h104);
        cyc(2);
        `CHK("pin off", 1'b0, woe)
        w(TKC_CTRL_OFFSET, 32'h106);
        cyc(2);
        `CHK("force oe", 1'b1, woe)
        `CHK("force low", 1'b0, wout)
        w(TKC_AUX_OFFSET, 32'h0);
        cyc(2);
        `CHK("release", 1'b0, woe)
        w(TKC_MASK_OFFSET, 32'h8);
        cyc(2);
        `CHK("irq err", 1'b1, irq)
        `CHK("irq oe", 1'b1, woe)
        w(TKC_EVENT_OFFSET, 32'h8);
        cyc(2);
        `CHK("irq clear", 1'b0, irq)
        r(12'h0F0);
        `CHK("unmapped", 1'b1, er)
        cyc(2);
        `CHK("irq again", 1'b1, irq)
        w(TKC_MASK_OFFSET, 32'h0);
        cyc(2);
        `CHK("irq masked", 1'b0, irq)
        w(TKC_EVENT_OFFSET, 32'hF);
        w(TKC_CTRL_OFFSET, 32'h116);
        cyc(2);
        `CHK("clk pin", 1'b1, woe)
        w(TKC_CTRL_OFFSET, 32'h316);
        cyc(2);
        `CHK("clk pin gated", 1'b0, woe)
    endtask

    task t_soft;
        pulse(1'b0);
        `CHK("invalid clr", 1'b0, tinv)
        w(TKC_LOCK_OFFSET, 32'hD8);
        w(TKC_CTRL_OFFSET, 32'h3F1F);
        cyc(4);
        r(TKC_CTRL_OFFSET);
        `CHK("swr only", 32'h1, rd)
        `CHK("swr trim", 4'h0, trim)
        `CHK("swr invalid", 1'b1, tinv)
        r(TKC_LOCK_OFFSET);
        `CHK("swr locks", 32'hF8, rd)
        w(TKC_CTRL_OFFSET, 32'h0);
        r(TKC_CTRL_OFFSET);
        `CHK("swr cleared", 32'h0, rd)
    endtask

    task t_locks;
        w(TKC_CTRL_OFFSET, 32'h104);
        cyc(20);
        w(TKC_STATUS_OFFSET, 32'h10);
        w(TKC_LOCK_OFFSET, 32'hD8);
        w(TKC_STATUS_OFFSET, 32'h0);
        `CHK("locked", 1'b1, time_count_enable)
        r(TKC_EVENT_OFFSET);
        `CHK("ignored ev", 1'b1, rd[TKC_EV_IGNORED])
        w(TKC_CTRL_OFFSET, 32'hC);
        w(TKC_STATUS_OFFSET, 32'h0);
        `CHK("um invalid", 1'b0, time_count_enable)
        pulse(1'b0);
        w(TKC_STATUS_OFFSET, 32'h10);
        `CHK("um tce clear", 1'b1, time_count_enable)
        w(TKC_STATUS_OFFSET, 32'h0);
        `CHK("um no flag", 1'b1, time_count_enable)
        pulse(1'b1);
        `CHK("overflow", 1'b1, tovf)
        w(TKC_STATUS_OFFSET, 32'h0);
        `CHK("um overflow", 1'b0, time_count_enable)
        w(TKC_LOCK_OFFSET, 32'hC8);
        w(TKC_CTRL_OFFSET, 32'h104);
        r(TKC_CTRL_OFFSET);
        `CHK("ctrl locked", 32'hC, rd)
        w(TKC_LOCK_OFFSET, 32'h40);
        `CHK("comp locked", 1'b0, cunl)
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b1;
        t_reset_priv;
        t_trim_gate;
        t_wake_irq;
        t_soft;
        t_locks;
        end_sim;
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        end_sim;
    end
endmodule
